// *** logic/dmsp_map.svh ***
// Register map, field positions, reset values and rate constants of the serial port.
// Assumes inclusion by dmsp_top.sv and the bench only, not by dmsp_pkg.sv.
`ifndef DMSP_MAP_SVH
`define DMSP_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DMSP_OFF_CTRL 12'h000
`define DMSP_OFF_TXD 12'h004
`define DMSP_OFF_RXD 12'h008
`define DMSP_OFF_STAT 12'h00C
`define DMSP_OFF_RATE 12'h010
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define DMSP_CTRL_MODE_LSB 0
`define DMSP_CTRL_RXEN 2
`define DMSP_CTRL_ADRM 3
`define DMSP_CTRL_T1RUN 4
`define DMSP_CTRL_T1EXT 5
`define DMSP_CTRL_SPLIT 6
`define DMSP_CTRL_RST 7'h00
`define DMSP_RATE_RST 8'h00
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define DMSP_STAT_TXF 0
`define DMSP_STAT_RXF 1
`define DMSP_STAT_OVR 2
`define DMSP_STAT_T1F 3
`define DMSP_STAT_TXBUSY 4
`define DMSP_STAT_TXBUF 5
`define DMSP_STAT_RXAV 6
`define DMSP_STAT_LVL_LSB 8
// ----------------------------------------------------------------
// Rate constants
// ----------------------------------------------------------------
`define DMSP_OVS 16
`define DMSP_DIV_SHIFT 12
`define DMSP_DIV_FIXED 64
`define DMSP_SMP_A 4'h7
`define DMSP_SMP_B 4'h8
`define DMSP_SMP_C 4'h9
`endif

// *** logic/dmsp_pkg.sv ***
// Types shared by the serial port design.
// Assumes dmsp_map.svh sits in the include path.
package dmsp_pkg;
  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_A8 = 2'h1,
    MODE_F9 = 2'h2,
    MODE_V9 = 2'h3
  } dmsp_mode_e;
  typedef enum logic [3:0] {
    AS_IDLE = 4'h1,
    AS_START = 4'h2,
    AS_DATA = 4'h4,
    AS_STOP = 4'h8
  } dmsp_async_e;
  typedef enum logic [2:0] {
    SH_IDLE = 3'h1,
    SH_TX = 3'h2,
    SH_RX = 3'h4
  } dmsp_shift_e;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic split;
    logic t1_ext;
    logic t1_run;
    logic adrm;
    logic rx_en;
    dmsp_mode_e mode;
  } dmsp_ctrl_s;
  typedef struct packed {
    logic valid;
    logic [8:0] data;
  } dmsp_word_s;
endpackage : dmsp_pkg

// *** logic/dmsp_top.sv ***
// Dual mode serial port: APB registers, bit-rate counter, async and shift engines.
// Assumes a 50 MHz clk as oscillator, synchronous active-low reset, pins from outside.
`timescale 1ns/100ps
`include "dmsp_map.svh"

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module dmsp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [LW-1:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_r != LW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign level = cnt_r;
  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc_ptr
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= inc_ptr(wp_r);
      if (pop) rp_r <= inc_ptr(rp_r);
      cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end
  end
endmodule : dmsp_fifo

module dmsp_top
  import dmsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe,
  output logic txd_o,
  // Counter 1 external input
  input wire logic t1_in,
  // Service request
  output logic serial_req
);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rxd_s1_r, rxd_s2_r, t1_s1_r, t1_s2_r, t1_s3_r;
  always_ff @(posedge clk) begin
    rxd_s1_r <= rxd_i;
    rxd_s2_r <= rxd_s1_r;
    t1_s1_r <= t1_in;
    t1_s2_r <= t1_s1_r;
    t1_s3_r <= t1_s2_r;
  end
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  dmsp_ctrl_s ctrl_r;
  logic [7:0] reload_r;
  logic pready_r, pslverr_r, serial_req_r;
  logic [31:0] prdata_r;
  logic txf_r, rxf_r, ovr_r, t1f_r;
  logic tx_buf_v_r;
  logic [8:0] tx_buf_r;
  wire acc = psel & penable & ~pready_r;
  wire done = psel & penable & pready_r;
  wire a_ctrl = (paddr == `DMSP_OFF_CTRL);
  wire a_txd = (paddr == `DMSP_OFF_TXD);
  wire a_rxd = (paddr == `DMSP_OFF_RXD);
  wire a_stat = (paddr == `DMSP_OFF_STAT);
  wire a_rate = (paddr == `DMSP_OFF_RATE);
  wire a_hit = a_ctrl | a_txd | a_rxd | a_stat | a_rate;
  wire tx_refuse = a_txd & pwrite & tx_buf_v_r;
  wire wr_ok = done & pwrite & ~pslverr_r;
  wire wr_ctrl = wr_ok & a_ctrl;
  wire wr_txd = wr_ok & a_txd;
  wire wr_stat = wr_ok & a_stat;
  wire wr_rate = wr_ok & a_rate;
  wire rd_rxd = done & ~pwrite & a_rxd;
  dmsp_mode_e mode;
  assign mode = ctrl_r.mode;
  wire m_shift = (mode == MODE_SHIFT);
  wire nine = (mode == MODE_F9) | (mode == MODE_V9);
  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  logic [3:0] div12_r;
  logic [1:0] div4_r;
  logic [7:0] t1_cnt_r;
  wire div12_en = (div12_r == 4'(`DMSP_DIV_SHIFT - 1));
  wire ext_rise = t1_s2_r & ~t1_s3_r;
  wire t1_step = ctrl_r.t1_run & (ctrl_r.t1_ext ? ext_rise : div12_en);
  wire t1_ovf = t1_step & (t1_cnt_r == 8'hFF);
  wire fix_en = (div4_r == 2'(`DMSP_DIV_FIXED / `DMSP_OVS - 1));
  wire tick = (mode == MODE_F9) ? fix_en : t1_ovf;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div12_r <= 4'h0;
      div4_r <= 2'h0;
      t1_cnt_r <= 8'h00;
    end else begin
      div12_r <= div12_en ? 4'h0 : div12_r + 4'h1;
      div4_r <= div4_r + 2'h1;
      if (t1_step) t1_cnt_r <= t1_ovf ? reload_r : t1_cnt_r + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Async receiver
  // ----------------------------------------------------------------
  dmsp_async_e rs_r;
  logic [3:0] rcnt_r, rbit_r;
  logic [8:0] rsh_r;
  logic [1:0] samp_r;
  logic ar_done_r;
  logic [8:0] ar_word_r;
  logic hold_v_r;
  wire vote = (samp_r[1] & samp_r[0]) | (samp_r[1] & rxd_s2_r) | (samp_r[0] & rxd_s2_r);
  wire at_vote = (rcnt_r == `DMSP_SMP_C);
  wire at_end = (rcnt_r == 4'(`DMSP_OVS - 1));
  wire [3:0] nbits = nine ? 4'h8 : 4'h7;
  wire [8:0] rx_frame = nine ? rsh_r : {1'b0, rsh_r[8:1]};
  wire addr_ok = ~ctrl_r.adrm | ~nine | rsh_r[8];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_r <= AS_IDLE;
      rcnt_r <= 4'h0;
      rbit_r <= 4'h0;
      rsh_r <= 9'h000;
      samp_r <= 2'h0;
      ar_done_r <= 1'b0;
      ar_word_r <= 9'h000;
    end else begin
      ar_done_r <= 1'b0;
      if (m_shift) begin
        rs_r <= AS_IDLE;
      end else if (tick) begin
        rcnt_r <= rcnt_r + 4'h1;
        if (rcnt_r == `DMSP_SMP_A || rcnt_r == `DMSP_SMP_B) samp_r <= {samp_r[0], rxd_s2_r};
        unique case (rs_r)
          AS_IDLE: begin
            rcnt_r <= 4'h0;
            if (ctrl_r.rx_en && !rxd_s2_r) rs_r <= AS_START;
          end
          AS_START: begin
            if (at_vote && vote) rs_r <= AS_IDLE;
            if (at_end) begin
              rs_r <= AS_DATA;
              rbit_r <= 4'h0;
            end
          end
          AS_DATA: begin
            if (at_vote) rsh_r <= {vote, rsh_r[8:1]};
            if (at_end) begin
              rbit_r <= rbit_r + 4'h1;
              if (rbit_r == nbits) rs_r <= AS_STOP;
            end
          end
          AS_STOP: begin
            if (at_vote) begin
              rs_r <= AS_IDLE;
              ar_done_r <= vote & addr_ok;
              ar_word_r <= rx_frame;
            end
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Async transmitter
  // ----------------------------------------------------------------
  dmsp_async_e ts_r;
  logic [3:0] tcnt_r, tbit_r;
  logic [8:0] tsh_r;
  logic tline_r, at_done_r;
  wire at_load = ~m_shift & tick & (ts_r == AS_IDLE) & tx_buf_v_r;
  wire t_end = (tcnt_r == 4'(`DMSP_OVS - 1));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ts_r <= AS_IDLE;
      tcnt_r <= 4'h0;
      tbit_r <= 4'h0;
      tsh_r <= 9'h000;
      tline_r <= 1'b1;
      at_done_r <= 1'b0;
    end else begin
      at_done_r <= 1'b0;
      if (m_shift) begin
        ts_r <= AS_IDLE;
        tline_r <= 1'b1;
      end else if (tick) begin
        tcnt_r <= tcnt_r + 4'h1;
        unique case (ts_r)
          AS_IDLE: begin
            tcnt_r <= 4'h0;
            if (tx_buf_v_r) begin
              tsh_r <= tx_buf_r;
              tline_r <= 1'b0;
              ts_r <= AS_START;
            end
          end
          AS_START: begin
            if (t_end) begin
              tline_r <= tsh_r[0];
              tbit_r <= 4'h0;
              ts_r <= AS_DATA;
            end
          end
          AS_DATA: begin
            if (t_end) begin
              tbit_r <= tbit_r + 4'h1;
              tsh_r <= {1'b0, tsh_r[8:1]};
              tline_r <= (tbit_r == nbits) ? 1'b1 : tsh_r[1];
              if (tbit_r == nbits) ts_r <= AS_STOP;
            end
          end
          AS_STOP: begin
            if (t_end) begin
              ts_r <= AS_IDLE;
              at_done_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Shift mode engine
  // ----------------------------------------------------------------
  dmsp_shift_e ss_r;
  logic [3:0] ph_r;
  logic [2:0] sbit_r;
  logic [7:0] ssh_r;
  logic sm_txd_r, sm_rxd_r;
  wire sm_tx_go = m_shift & (ss_r == SH_IDLE) & tx_buf_v_r;
  wire sm_rx_go = m_shift & (ss_r == SH_IDLE) & ~tx_buf_v_r & ctrl_r.rx_en & ~rxf_r & ~hold_v_r
    & ~sm_rxd_r;
  wire ph_last = (ph_r == 4'(`DMSP_DIV_SHIFT - 1));
  wire ph_rise = (ph_r == 4'(`DMSP_DIV_SHIFT / 2));
  wire s_last = ph_last & (sbit_r == 3'h7);
  wire tx_load = at_load | sm_tx_go;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_r <= SH_IDLE;
      ph_r <= 4'h0;
      sbit_r <= 3'h0;
      ssh_r <= 8'h00;
      sm_txd_r <= 1'b0;
      sm_rxd_r <= 1'b0;
    end else begin
      sm_txd_r <= 1'b0;
      sm_rxd_r <= 1'b0;
      ph_r <= ph_last ? 4'h0 : ph_r + 4'h1;
      unique case (ss_r)
        SH_IDLE: begin
          ph_r <= 4'h0;
          sbit_r <= 3'h0;
          if (sm_tx_go) begin
            ssh_r <= tx_buf_r[7:0];
            ss_r <= SH_TX;
          end else if (sm_rx_go) begin
            ss_r <= SH_RX;
          end
        end
        SH_TX: begin
          if (ph_last) begin
            ssh_r <= {1'b0, ssh_r[7:1]};
            sbit_r <= sbit_r + 3'h1;
          end
          if (s_last) begin
            ss_r <= SH_IDLE;
            sm_txd_r <= 1'b1;
          end
        end
        SH_RX: begin
          if (ph_rise) ssh_r <= {rxd_s2_r, ssh_r[7:1]};
          if (ph_last) sbit_r <= sbit_r + 3'h1;
          if (s_last) begin
            ss_r <= SH_IDLE;
            sm_rxd_r <= 1'b1;
          end
        end
        default: ss_r <= SH_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Receive holding buffer and FIFO
  // ----------------------------------------------------------------
  dmsp_word_s hold_r;
  logic fifo_in_ready, fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  wire rx_done = ar_done_r | sm_rxd_r;
  wire [8:0] rx_word = sm_rxd_r ? {1'b0, ssh_r} : ar_word_r;
  wire hold_push = hold_r.valid & fifo_in_ready;
  wire rx_ovr = rx_done & hold_r.valid & ~fifo_in_ready;
  assign hold_v_r = hold_r.valid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_r <= '0;
    end else if (rx_done && (!hold_r.valid || fifo_in_ready)) begin
      hold_r <= '{valid: 1'b1, data: rx_word};
    end else if (hold_push) begin
      hold_r.valid <= 1'b0;
    end
  end
  dmsp_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(hold_r.valid),
    .in_ready(fifo_in_ready),
    .in_data(hold_r.data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_rxd),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );
  // ----------------------------------------------------------------
  // Registers and flags
  // ----------------------------------------------------------------
  wire tx_done = at_done_r | sm_txd_r;
  wire tx_busy = (ts_r != AS_IDLE) | (ss_r == SH_TX);
  wire [31:0] stat_word = {{(24-LW){1'b0}}, fifo_level, 1'b0, fifo_out_valid, tx_buf_v_r,
    tx_busy, t1f_r, ovr_r, rxf_r, txf_r};
  wire [31:0] rd_mux = a_ctrl ? {25'h0, ctrl_r} :
                       a_rxd ? {23'h0, fifo_out_data} :
                       a_stat ? stat_word :
                       a_rate ? {24'h0, reload_r} : 32'h0;
  function automatic logic flag_nxt(input logic cur, input logic set, input logic clr);
    flag_nxt = set | (cur & ~clr);
  endfunction : flag_nxt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ctrl_r <= `DMSP_CTRL_RST;
      reload_r <= `DMSP_RATE_RST;
      tx_buf_v_r <= 1'b0;
      tx_buf_r <= 9'h000;
      txf_r <= 1'b0;
      rxf_r <= 1'b0;
      ovr_r <= 1'b0;
      t1f_r <= 1'b0;
      serial_req_r <= 1'b0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc & (~a_hit | tx_refuse);
      if (acc) prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      if (wr_ctrl) ctrl_r <= pwdata[6:0];
      if (wr_rate) reload_r <= pwdata[7:0];
      if (wr_txd) begin
        tx_buf_r <= pwdata[8:0];
        tx_buf_v_r <= 1'b1;
      end else if (tx_load) begin
        tx_buf_v_r <= 1'b0;
      end
      txf_r <= flag_nxt(txf_r, tx_done, wr_stat & pwdata[`DMSP_STAT_TXF]);
      rxf_r <= flag_nxt(rxf_r, rx_done & ~rx_ovr, wr_stat & pwdata[`DMSP_STAT_RXF]);
      ovr_r <= flag_nxt(ovr_r, rx_ovr, wr_stat & pwdata[`DMSP_STAT_OVR]);
      t1f_r <= flag_nxt(t1f_r, t1_ovf & ~ctrl_r.split, wr_stat & pwdata[`DMSP_STAT_T1F]);
      serial_req_r <= txf_r | rxf_r;
    end
  end
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic txd_r, rxd_o_r, rxd_oe_r;
  wire sclk = (ss_r != SH_IDLE) & (ph_r >= 4'(`DMSP_DIV_SHIFT / 2));
  wire txd_nxt = m_shift ? ((ss_r == SH_IDLE) | sclk) : tline_r;
  wire rxd_oe_nxt = (ss_r == SH_TX);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txd_r <= 1'b1;
      rxd_o_r <= 1'b1;
      rxd_oe_r <= 1'b0;
    end else begin
      txd_r <= txd_nxt;
      rxd_o_r <= ssh_r[0];
      rxd_oe_r <= rxd_oe_nxt;
    end
  end
  assign txd_o = txd_r;
  assign rxd_o = rxd_o_r;
  assign rxd_oe = rxd_oe_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign serial_req = serial_req_r;
endmodule : dmsp_top

// *** tb/dmsp_assertions.sv ***
// Checker for the serial port: APB timing, shift clock, fixed-rate bit length.
// Assumes it is bound to dmsp_top and sees only its ports.
`timescale 1ns/100ps
module dmsp_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic rxd_o,
  input wire logic rxd_oe,
  input wire logic txd_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Mode shadow and low-run counter
  // ----------------------------------------
  logic [1:0] mode_r;
  logic [15:0] low_r;
  wire acc = psel && penable && !pready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= 2'h0;
      low_r <= 16'h0000;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 12'h000) mode_r <= pwdata[1:0];
      low_r <= txd_o ? 16'h0000 : low_r + 16'h0001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_clk_lo;
    !txd_o [*6];
  endsequence
  sequence s_clk_hi;
    txd_o [*6];
  endsequence
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  property p_rdy_wait;
    acc |=> pready;
  endproperty
  property p_rdy_cause;
    pready |-> $past(psel && penable);
  endproperty
  property p_err_map;
    acc && paddr > 12'h010 |=> pslverr;
  endproperty
  property p_ok_read;
    acc && !pwrite && paddr inside {12'h000, 12'h008, 12'h00C, 12'h010} |=> !pslverr;
  endproperty
  property p_shift_clk;
    $fell(txd_o) && rxd_oe |-> s_clk_lo ##1 s_clk_hi;
  endproperty
  property p_shift_dat;
    rxd_oe && $past(rxd_oe) && !$fell(txd_o) |-> $stable(rxd_o);
  endproperty
  property p_oe_mode;
    rxd_oe |-> mode_r == 2'h0;
  endproperty
  property p_f9_bit;
    $rose(txd_o) && mode_r == 2'h2 |-> low_r[5:0] == 6'h00;
  endproperty
  a_rdy_one: assert property (p_rdy_one)
    else $error("pready held past one cycle");
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("access not answered after one wait");
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("pready without access");
  a_err_map: assert property (p_err_map)
    else $error("unmapped access without pslverr");
  a_ok_read: assert property (p_ok_read)
    else $error("mapped read flagged");
  a_shift_clk: assert property (p_shift_clk)
    else $error("shift clock not 6 low 6 high");
  a_shift_dat: assert property (p_shift_dat)
    else $error("shift data moved mid bit");
  a_oe_mode: assert property (p_oe_mode)
    else $error("data pin driven outside shift mode");
  a_f9_bit: assert property (p_f9_bit)
    else $error("fixed-rate low run not whole bits");
endmodule : dmsp_assertions

bind dmsp_top dmsp_assertions u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .rxd_o(rxd_o),
  .rxd_oe(rxd_oe),
  .txd_o(txd_o)
);

// *** tb/dmsp_peer.sv ***
// Far-end UART: sends frames into the receive pin, captures frames from the transmit pin.
// Assumes bit times in bench clock cycles.
`timescale 1ns/100ps
module dmsp_peer (
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Frame out, optional 3-cycle spike in bit sp
  task automatic send(input logic [8:0] d, input int nb, input int bt, input int sp);
    logic v;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      v = (i == nb) ? 1'b1 : d[i];
      rxd <= v;
      if (i == sp) begin
        repeat (31) @(posedge clk);
        rxd <= ~v;
        repeat (3) @(posedge clk);
        rxd <= v;
        repeat (bt - 34) @(posedge clk);
      end else begin
        repeat (bt) @(posedge clk);
      end
    end
  endtask : send
  task automatic glitch(input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask : glitch
  // Shift-mode data source, new bit after each clock fall
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      while (txd !== 1'b0) @(posedge clk);
      rxd <= d[i];
      while (txd !== 1'b1) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : shift_in
  // Frame in, sampled mid bit
  task automatic recv(output logic [8:0] d, output logic st, input int nb, input int bt);
    int w;
    d = 9'h000;
    w = 0;
    while (txd !== 1'b0 && w < 8000) begin
      @(posedge clk);
      w++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge clk);
      d[i] = txd;
    end
    repeat (bt) @(posedge clk);
    st = txd;
  endtask : recv
endmodule : dmsp_peer

// *** tb/dmsp_bench.sv ***
// Self-checking bench for the serial port: APB master, far-end model, scenarios.
// Assumes the design files and dmsp_map.svh on the include path.
`timescale 1ns/100ps
`include "dmsp_map.svh"
module dmsp_bench
  import dmsp_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic rxd_o, rxd_oe, txd_o, serial_req, peer_rxd, t1_in, t1_on, er, st;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] d9;
  logic [2:0] tc;
  int num_errors, n_compared, cyc;
  wire rxd_line = rxd_oe ? rxd_o : peer_rxd;
  dmsp_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .t1_in(t1_in),
    .serial_req(serial_req));
  dmsp_peer u_peer (.clk(clk), .txd(txd_o), .rxd(peer_rxd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    tc <= tc + 3'h1;
    t1_in <= t1_on & tc[2];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] ctl(dmsp_mode_e m, logic [4:0] f);
    dmsp_ctrl_s c;
    c = {f, m};
    return {25'h0, c};
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, `DMSP_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, `DMSP_OFF_RATE, 32'h0);
    chk("rate", 32'h0, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
  endtask : t_reset
  task automatic t_duplex();
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_F9, 5'h01));
    fork
      begin
        u_peer.send(9'h1A5, 9, 64, 0);
        u_peer.send(9'h05A, 9, 64, -1);
      end
      begin
        apb(1'b1, `DMSP_OFF_TXD, 32'h1C3);
        u_peer.recv(d9, st, 9, 64);
        chk("f9 tx", 32'h3C3, {22'h0, st, d9});
      end
    join
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("level", 32'h2, (rd >> 8) & 32'h1F);
    chk("rxf", 32'h2, rd & 32'h2);
    chk("req", 32'h1, {31'h0, serial_req});
    apb(1'b0, `DMSP_OFF_RXD, 32'h0);
    chk("rx1", 32'h1A5, rd);
    apb(1'b0, `DMSP_OFF_RXD, 32'h0);
    chk("rx2", 32'h05A, rd);
    apb(1'b1, `DMSP_OFF_STAT, 32'hF);
    repeat (3) @(posedge clk);
    chk("req off", 32'h0, {31'h0, serial_req});
  endtask : t_duplex
  task automatic t_false();
    u_peer.glitch(16);
    repeat (800) @(posedge clk);
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("no frame", 32'h0, rd & 32'h40);
  endtask : t_false
  task automatic t_addr();
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_F9, 5'h03));
    u_peer.send(9'h033, 9, 64, -1);
    u_peer.send(9'h1C4, 9, 64, -1);
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("adr lvl", 32'h1, (rd >> 8) & 32'h1F);
    apb(1'b0, `DMSP_OFF_RXD, 32'h0);
    chk("adr", 32'h1C4, rd);
  endtask : t_addr
  task automatic t_rate1();
    apb(1'b1, `DMSP_OFF_RATE, 32'hFF);
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_A8, 5'h14));
    apb(1'b1, `DMSP_OFF_STAT, 32'hF);
    fork
      begin
        u_peer.recv(d9, st, 8, 192);
        chk("a8 tx1", 32'h23C, {22'h0, st, d9});
        u_peer.recv(d9, st, 8, 192);
        chk("a8 tx2", 32'h281, {22'h0, st, d9});
      end
      begin
        apb(1'b1, `DMSP_OFF_TXD, 32'h3C);
        while (txd_o !== 1'b0) @(posedge clk);
        apb(1'b1, `DMSP_OFF_TXD, 32'h81);
        apb(1'b0, `DMSP_OFF_STAT, 32'h0);
        chk("txbuf", 32'h20, rd & 32'h20);
        apb(1'b1, `DMSP_OFF_TXD, 32'h77);
        chk("full wr", 32'h1, {31'h0, er});
      end
    join
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("t1f split", 32'h0, rd & 32'h8);
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_A8, 5'h04));
    repeat (20) @(posedge clk);
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("t1f", 32'h8, rd & 32'h8);
  endtask : t_rate1
  task automatic t_ext();
    t1_on = 1'b1;
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_V9, 5'h0C));
    fork
      u_peer.recv(d9, st, 9, 128);
      apb(1'b1, `DMSP_OFF_TXD, 32'h1B2);
    join
    chk("v9 tx", 32'h3B2, {22'h0, st, d9});
    t1_on = 1'b0;
  endtask : t_ext
  task automatic t_shift();
    logic [7:0] v;
    logic oe;
    int n, c0;
    oe = 1'b1;
    c0 = 0;
    apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_SHIFT, 5'h00));
    apb(1'b1, `DMSP_OFF_TXD, 32'hA5);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (txd_o !== 1'b0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      while (txd_o !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      v[i] = rxd_o;
      oe = oe & rxd_oe;
      if (i == 0) c0 = cyc;
    end
    chk("shift data", 32'hA5, {24'h0, v});
    chk("shift oe", 32'h1, {31'h0, oe});
    chk("shift rate", 32'd84, cyc - c0);
  endtask : t_shift
  task automatic t_shrx();
    apb(1'b1, `DMSP_OFF_STAT, 32'hF);
    fork
      u_peer.shift_in(8'h6B);
      apb(1'b1, `DMSP_OFF_CTRL, ctl(MODE_SHIFT, 5'h01));
    join
    repeat (150) @(posedge clk);
    apb(1'b0, `DMSP_OFF_STAT, 32'h0);
    chk("shift rx lvl", 32'h1, (rd >> 8) & 32'h1F);
    apb(1'b0, `DMSP_OFF_RXD, 32'h0);
    chk("shift rx", 32'h06B, rd);
  endtask : t_shrx
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    t1_in = 1'b0;
    t1_on = 1'b0;
    tc = 3'h0;
    cyc = 0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_duplex();
    t_false();
    t_addr();
    t_rate1();
    t_ext();
    t_shift();
    t_shrx();
    print_verdict();
  end
endmodule : dmsp_bench
